// *** verilog/jtpg_pkg.sv ***
package jtpg_pkg;
    // Test pattern selection codes
    localparam int        TSEL_W      = 4;
    localparam logic [3:0] TSEL_NONE   = 4'h0;  // Normal link, zero payload
    localparam logic [3:0] TSEL_LONG   = 4'h1;  // Long transport pattern
    localparam logic [3:0] TSEL_D21    = 4'h2;  // Continuous D21.5
    localparam logic [3:0] TSEL_K28    = 4'h3;  // Continuous K28.5
    localparam logic [3:0] TSEL_REPILA = 4'h4;  // Alignment sequence forever
    localparam logic [3:0] TSEL_RANDOM_JITTER_PATTERN   = 4'h5;  // Modified random pattern

    // Link configuration
    localparam int         CFG_W           = 5;
    localparam logic [4:0] CFG_SINGLE_LINK = 5'h0f;  // Only configuration with one link

    // Octet stream layout: {k flag, octet}
    localparam int         OCT_W    = 9;
    localparam int         K_BIT    = 8;
    localparam logic [7:0] OCT_D21_5 = 8'hb5;
    localparam logic [7:0] OCT_K28_5 = 8'hbc;
    localparam logic [7:0] OCT_K28_0 = 8'h1c;  // Multiframe start marker
    localparam logic [7:0] OCT_K28_3 = 8'h7c;  // Multiframe end marker
    localparam logic [7:0] OCT_ZERO  = 8'h00;

    // Long transport pattern geometry
    localparam int         OCTETS_PER_SAMPLE = 2;   // 16-bit containers
    localparam int         LONG_EXTRA_FRAMES = 2;   // Frames beyond the walking phase
    localparam int         WORD_W            = 16;
    localparam int         HI_LSB            = 8;

    // Counter widths and reset values
    localparam int          IDX_W      = 8;
    localparam int          FRM_W      = 16;
    localparam int          MFC_W      = 4;
    localparam logic [7:0]  IDX_RST    = 8'h00;
    localparam logic [15:0] FRM_RST    = 16'h0000;
    localparam logic [3:0]  MFC_RST    = 4'h0;

    // Modified random pattern, entry 0 sent first
    localparam int          RANDOM_JITTER_PATTERN_LEN  = 12;
    localparam logic [3:0]  RANDOM_JITTER_PATTERN_LAST = 4'hb;
    localparam logic [3:0]  RANDOM_JITTER_PATTERN_RST  = 4'h0;
    localparam logic [11:0][7:0] RANDOM_JITTER_PATTERN_TAB = {8'h59, 8'h35, 8'hfb, 8'h5e, 8'h14, 8'hb3,
                                             8'h8f, 8'h6b, 8'h47, 8'h23, 8'hd7, 8'hbe};

    // Link sequencing states
    typedef enum logic [4:0] {
        ST_OFF  = 5'b00001,
        ST_CGS  = 5'b00010,
        ST_ILAS = 5'b00100,
        ST_DATA = 5'b01000,
        ST_RAW  = 5'b10000
    } link_state_e;
endpackage

// *** verilog/octet_if.sv ***
// Valid/ready octet stream between the generator, the FIFO and the lane stage
interface octet_if #(parameter int W = 9);
    logic [W-1:0] data;   // Payload
    logic         valid;  // Source has a word
    logic         ready;  // Sink takes it

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// *** verilog/octet_fifo.sv ***
module octet_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clocking
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic flush_i,
    // Streams
    octet_if.snk      wr,
    octet_if.src      rd
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage, not reset: only valid words are read
    logic [AW:0]      wr_ptr;        // Extra bit tells full from empty
    logic [AW:0]      rd_ptr;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    assign empty    = (wr_ptr == rd_ptr);
    assign full     = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign wr.ready = !full && !flush_i;
    assign rd.valid = !empty;
    assign rd.data  = mem[rd_ptr[AW-1:0]];
    assign push     = ce_i && wr.valid && wr.ready;
    assign pop      = ce_i && rd.valid && rd.ready;

    // Write side
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= wr.data;
        end
    end

    // Pointers; flush drops stale octets when the link goes down
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (ce_i && flush_i)) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // A full FIFO must refuse the source
    a_fifo_full_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        full |-> !wr.ready && !empty)
        else $error("fifo full but still accepting");
endmodule // octet_fifo

// *** verilog/long_pattern_word.sv ***
module long_pattern_word
    import jtpg_pkg::*;
#(
    parameter int M  = 2,
    parameter int S  = 1,
    parameter int N  = 15,
    parameter int CS = 1
) (
    // Position in the pattern
    input  wire logic [jtpg_pkg::FRM_W-1:0]  frame_idx_i,
    input  wire logic [jtpg_pkg::IDX_W-1:0]  sample_pos_i,
    // 16-bit container
    output logic      [jtpg_pkg::WORD_W-1:0] word_o
);
    localparam logic [15:0] WALK_FRAMES = 16'(M * S);
    localparam logic [15:0] MID_VALUE   = 16'(1 << (N - 1));

    logic [15:0] conv;     // Converter index within the link
    logic [15:0] sample_position_index;      // Sample position within the converter
    logic [15:0] data;     // N-bit sample value
    logic        ctrl_on;  // Walking control bit

    // Sample value per frame; both links share one generator
    always_comb begin
        conv = 16'(sample_pos_i) / 16'(S);
        sample_position_index  = 16'(sample_pos_i) % 16'(S);
        if (frame_idx_i == FRM_RST) begin
            data = conv + 16'h0001;                        // RULE1 RULE2 RULE3 RULE15
        end else if (frame_idx_i == FRM_RST + 16'h0001) begin
            data = sample_position_index + 16'h0001;                         // RULE4
        end else begin
            data = MID_VALUE;                              // RULE5
        end
        // Frame i marks sample i mod S of converter i/S, i.e. position i
        ctrl_on = (CS > 0) && (frame_idx_i < WALK_FRAMES)
                  && (frame_idx_i == 16'(sample_pos_i));  // RULE6 RULE7
        word_o  = 16'(data << CS) | 16'(ctrl_on);
    end
endmodule // long_pattern_word

// *** verilog/jesd_tx_test_pattern_gen.sv ***
// Overview of operation
// RULE1: Frame zero samples hold converter index plus one
// RULE2: Converter indices restart per link; two links
// RULE3: Single link numbers AI0 AQ1 BI2 BQ3 (code keeps M converters per link and only turns off the B lanes)
// RULE4: Frame one samples hold position plus one
// RULE5: Later frames hold two to N minus one
// RULE6: One control bit walks over first M*S frames
// RULE7: Control bits zero after walking phase
// RULE8: Pattern starts after alignment, repeats forever
// RULE9: D21.5 mode sends only D21.5
// RULE10: K28.5 mode sends only K28.5
// RULE11: Repeat mode resends alignment, never data
// RULE12: Sync request forces comma sync, then alignment
// RULE13: Random mode cycles twelve fixed octets
// RULE14: Period is K times ceil((M*S+2)/K)
// RULE15: Link A and B carry identical pattern
// RULE16: Select mode only while link disabled
// RULE17: Frame counter clears at start, each period
module jesd_tx_test_pattern_gen
    import jtpg_pkg::*;
#(
    parameter int M          = 2,   // Converters per link
    parameter int S          = 1,   // Samples per converter per frame
    parameter int K          = 10,  // Frames per multiframe
    parameter int N          = 15,  // Sample resolution
    parameter int CS         = 1,   // Control bits per sample
    parameter int ILAS_MF    = 4,   // Multiframes in one alignment sequence
    parameter int FIFO_DEPTH = 16
) (
    // Clock, reset, enable
    input  wire logic                          MCLK_I,
    input  wire logic                          RESETN_I,
    input  wire logic                          CE_I,
    // Configuration
    input  wire logic                          LINK_EN_I,
    input  wire logic [jtpg_pkg::TSEL_W-1:0]   TEST_PATTERN_SELECT_I,
    input  wire logic [jtpg_pkg::CFG_W-1:0]    LINK_CONFIG_MODE_I,
    // Receiver side
    input  wire logic                          SYNC_N_I,
    // Lane interface
    input  wire logic                          LANE_READY_I,
    output logic                               LANE_VALID_O,
    output logic [7:0]                         LANE_A0_O,
    output logic                               LANE_A0_K_O,
    output logic [7:0]                         LANE_B0_O,
    output logic                               LANE_B0_K_O,
    output logic                               LANE_B_EN_O,
    // Status
    output logic                               LINK_DATA_O
);
    import jtpg_pkg::*;

    // Pattern geometry
    localparam int          F         = OCTETS_PER_SAMPLE * M * S;  // Octets per frame
    localparam int          P         = K * ((M * S + LONG_EXTRA_FRAMES + K - 1) / K);
    localparam logic [7:0]  OCT_LAST  = 8'(F - 1);
    localparam logic [7:0]  MF_LAST   = 8'(K - 1);
    localparam logic [3:0]  ILAS_LAST = 4'(ILAS_MF - 1);
    localparam logic [15:0] PER_LAST  = 16'(P - 1);                // RULE14
    localparam logic [15:0] WALK_END  = 16'(M * S);
    localparam logic [15:0] MID_WORD  = 16'(1 << (N - 1 + CS));

    // Synchroniser on the receiver's request pin
    logic        sync_meta;     // First stage, read only by sync_s
    logic        sync_s;        // Request line, high when idle
    logic        sync_req;      // Receiver wants comma sync

    // Latched configuration
    logic [3:0]  tsel;          // Active test pattern
    logic [4:0]  cfg;           // Active link configuration

    // Sequencing
    link_state_e state;         // Link phase
    logic [7:0]  oct_idx;       // Octet within frame
    logic [7:0]  mf_frame;      // Frame within multiframe
    logic [3:0]  mf_cnt;        // Multiframe within alignment sequence
    logic [15:0] frame_idx;     // Frame within pattern period
    logic [3:0]  random_jitter_pattern_idx;      // Position in random pattern
    logic        frame_end;     // Last octet of a frame
    logic        mf_end;        // Last octet of a multiframe
    logic        ilas_end;      // Last octet of the alignment sequence
    logic        push;          // Octet accepted into the FIFO

    // Generated octet
    logic [8:0]  gen_data;      // {k, octet}
    logic [15:0] lt_word;       // Long pattern container

    // Output stage
    logic        out_take;      // Output register may load

    octet_if #(.W(OCT_W)) wr_bus ();
    octet_if #(.W(OCT_W)) rd_bus ();

    // Two-flop synchroniser; only the second stage feeds logic
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            sync_meta <= 1'b1;
            sync_s    <= 1'b1;
        end else if (CE_I) begin
            sync_meta <= SYNC_N_I;
            sync_s    <= sync_meta;
        end
    end

    assign sync_req = !sync_s;

    // Mode and configuration only follow the inputs while the link is down,
    // so a change mid-stream cannot tear a frame apart
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            tsel <= TSEL_NONE;
            cfg  <= CFG_SINGLE_LINK;
        end else if (CE_I && !LINK_EN_I) begin
            tsel <= TEST_PATTERN_SELECT_I;   // RULE16
            cfg  <= LINK_CONFIG_MODE_I;
        end
    end

    // Position flags
    assign frame_end = (oct_idx == OCT_LAST);
    assign mf_end    = frame_end && (mf_frame == MF_LAST);
    assign ilas_end  = mf_end && (mf_cnt == ILAS_LAST);
    assign push      = CE_I && wr_bus.valid && wr_bus.ready;

    // Link phase sequencing
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            state <= ST_OFF;
        end else if (CE_I) begin
            if (!LINK_EN_I) begin
                state <= ST_OFF;
            end else begin
                unique case (state)
                    ST_OFF: begin
                        // Character modes bypass the link layer entirely
                        if (tsel == TSEL_D21 || tsel == TSEL_K28 || tsel == TSEL_RANDOM_JITTER_PATTERN) begin
                            state <= ST_RAW;
                        end else begin
                            state <= ST_CGS;
                        end
                    end
                    ST_CGS: begin
                        // Leave only after at least one comma went out
                        if (!sync_req && push) begin
                            state <= ST_ILAS;   // RULE12
                        end
                    end
                    ST_ILAS: begin
                        if (sync_req) begin
                            state <= ST_CGS;    // RULE12
                        end else if (push && ilas_end && tsel != TSEL_REPILA) begin
                            state <= ST_DATA;   // RULE8
                        end
                    end
                    ST_DATA: begin
                        if (sync_req) begin
                            state <= ST_CGS;
                        end
                    end
                    ST_RAW: begin
                        state <= ST_RAW;
                    end
                endcase
            end
        end
    end

    // Frame and multiframe counters; they are zero on entry to the alignment
    // sequence and wrap back to zero at its end, so data starts at frame 0
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            oct_idx   <= IDX_RST;
            mf_frame  <= IDX_RST;
            mf_cnt    <= MFC_RST;
            frame_idx <= FRM_RST;
        end else if (CE_I) begin
            if (state != ST_ILAS && state != ST_DATA) begin
                oct_idx   <= IDX_RST;
                mf_frame  <= IDX_RST;
                mf_cnt    <= MFC_RST;
                frame_idx <= FRM_RST;                        // RULE17
            end else if (state == ST_ILAS && sync_req) begin
                oct_idx   <= IDX_RST;
                mf_frame  <= IDX_RST;
                mf_cnt    <= MFC_RST;
            end else if (push) begin
                oct_idx <= frame_end ? IDX_RST : oct_idx + 8'h01;
                if (frame_end) begin
                    mf_frame <= mf_end ? IDX_RST : mf_frame + 8'h01;
                    if (state == ST_ILAS && mf_end) begin
                        // Repeat mode simply starts the next sequence here
                        mf_cnt <= ilas_end ? MFC_RST : mf_cnt + 4'h1;   // RULE11
                    end
                    if (state == ST_DATA) begin
                        // Pattern repeats as long as the link runs
                        frame_idx <= (frame_idx == PER_LAST) ? FRM_RST
                                     : frame_idx + 16'h0001;            // RULE8 RULE17
                    end
                end
            end
        end
    end

    // Random pattern pointer
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            random_jitter_pattern_idx <= RANDOM_JITTER_PATTERN_RST;
        end else if (CE_I) begin
            if (state != ST_RAW) begin
                random_jitter_pattern_idx <= RANDOM_JITTER_PATTERN_RST;
            end else if (push) begin
                random_jitter_pattern_idx <= (random_jitter_pattern_idx == RANDOM_JITTER_PATTERN_LAST) ? RANDOM_JITTER_PATTERN_RST : random_jitter_pattern_idx + 4'h1;  // RULE13
            end
        end
    end

    long_pattern_word #(
        .M  (M),
        .S  (S),
        .N  (N),
        .CS (CS)
    ) u_word (
        .frame_idx_i  (frame_idx),
        .sample_pos_i (oct_idx >> 1),
        .word_o       (lt_word)
    );

    // Octet selection for the current phase
    always_comb begin
        gen_data = {1'b0, OCT_ZERO};
        unique case (state)
            ST_OFF: begin
                gen_data = {1'b0, OCT_ZERO};
            end
            ST_CGS: begin
                gen_data = {1'b1, OCT_K28_5};
            end
            ST_ILAS: begin
                // Simplified sequence: markers framing an index ramp
                if (oct_idx == IDX_RST && mf_frame == IDX_RST) begin
                    gen_data = {1'b1, OCT_K28_0};
                end else if (mf_end) begin
                    gen_data = {1'b1, OCT_K28_3};
                end else begin
                    gen_data = {1'b0, oct_idx};
                end
            end
            ST_DATA: begin
                if (tsel == TSEL_LONG) begin
                    // Most significant octet of each container goes first
                    gen_data = {1'b0, oct_idx[0] ? lt_word[HI_LSB-1:0]
                                                 : lt_word[WORD_W-1:HI_LSB]};
                end
            end
            ST_RAW: begin
                if (tsel == TSEL_D21) begin
                    gen_data = {1'b0, OCT_D21_5};          // RULE9
                end else if (tsel == TSEL_K28) begin
                    gen_data = {1'b1, OCT_K28_5};          // RULE10
                end else begin
                    gen_data = {1'b0, RANDOM_JITTER_PATTERN_TAB[random_jitter_pattern_idx]}; // RULE13
                end
            end
        endcase
    end

    assign wr_bus.data  = gen_data;
    assign wr_bus.valid = (state != ST_OFF);

    // Elastic buffer between generator and lanes; a stalled serializer backs
    // up through it and freezes the counters above
    octet_fifo #(
        .WIDTH (OCT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (MCLK_I),
        .rst_n_i (RESETN_I),
        .ce_i    (CE_I),
        .flush_i (!LINK_EN_I),
        .wr      (wr_bus.snk),
        .rd      (rd_bus.src)
    );

    assign out_take     = !LANE_VALID_O || LANE_READY_I;
    assign rd_bus.ready = out_take && LINK_EN_I;

    // Lane output register; both links see the same octet
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            LANE_VALID_O <= 1'b0;
            LANE_A0_O    <= OCT_ZERO;
            LANE_A0_K_O  <= 1'b0;
            LANE_B0_O    <= OCT_ZERO;
            LANE_B0_K_O  <= 1'b0;
        end else if (CE_I) begin
            if (!LINK_EN_I) begin
                LANE_VALID_O <= 1'b0;
            end else if (out_take) begin
                LANE_VALID_O <= rd_bus.valid;
                if (rd_bus.valid) begin
                    LANE_A0_O   <= rd_bus.data[K_BIT-1:0];
                    LANE_A0_K_O <= rd_bus.data[K_BIT];
                    LANE_B0_O   <= rd_bus.data[K_BIT-1:0];   // RULE15
                    LANE_B0_K_O <= rd_bus.data[K_BIT];
                end
            end
        end
    end

    // Status: second link lanes and data phase
    always_ff @(posedge MCLK_I) begin
        if (!RESETN_I) begin
            LANE_B_EN_O <= 1'b0;
            LINK_DATA_O <= 1'b0;
        end else if (CE_I) begin
            LANE_B_EN_O <= (cfg != CFG_SINGLE_LINK);          // RULE2 RULE3
            LINK_DATA_O <= (state == ST_DATA);
        end
    end

    a_sync_to_cgs: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE12
        (CE_I && LINK_EN_I && sync_req && (state == ST_ILAS || state == ST_DATA))
        |=> state == ST_CGS)
        else $error("sync request did not restart comma sync");

    a_cgs_comma: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE12
        (state == ST_CGS && push) |-> gen_data == {1'b1, OCT_K28_5})
        else $error("comma sync sent a non-comma");

    a_d21_stream: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE9
        (push && state == ST_RAW && tsel == TSEL_D21) |-> gen_data == {1'b0, OCT_D21_5})
        else $error("D21.5 mode sent another character");

    a_k28_stream: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE10
        (push && state == ST_RAW && tsel == TSEL_K28) |-> gen_data == {1'b1, OCT_K28_5})
        else $error("K28.5 mode sent another character");

    a_random_jitter_pattern_wrap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE13
        (push && state == ST_RAW && tsel == TSEL_RANDOM_JITTER_PATTERN && random_jitter_pattern_idx == RANDOM_JITTER_PATTERN_LAST)
        |=> (random_jitter_pattern_idx == RANDOM_JITTER_PATTERN_RST) && (gen_data[7:0] == RANDOM_JITTER_PATTERN_TAB[0]))
        else $error("random pattern did not restart after twelve octets");

    a_ilas_repeat: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE11
        (CE_I && LINK_EN_I && !sync_req && state == ST_ILAS && tsel == TSEL_REPILA)
        |=> state == ST_ILAS)
        else $error("repeat mode left the alignment sequence");

    a_long_start: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE8
        (CE_I && LINK_EN_I && !sync_req && push && ilas_end && state == ST_ILAS
         && tsel == TSEL_LONG) |=> state == ST_DATA && frame_idx == FRM_RST && oct_idx == IDX_RST)
        else $error("long pattern did not start at frame zero");

    a_period_wrap: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE17
        (CE_I && LINK_EN_I && !sync_req && state == ST_DATA && push && frame_end
         && frame_idx == PER_LAST) |=> frame_idx == FRM_RST)
        else $error("pattern period did not wrap");

    a_mid_value: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // RULE5
        (state == ST_DATA && tsel == TSEL_LONG && frame_idx >= WALK_END
         && frame_idx > 16'h0001 && !oct_idx[0]) |-> gen_data[7:0] == MID_WORD[15:8])
        else $error("late frame sample is not mid value");
endmodule // jesd_tx_test_pattern_gen

// *** verification/rx_partner.sv ***
// Receiver model: paces the lane stream and raises sync requests
module rx_partner (
    // Bench controls
    input  wire logic clk_i,
    input  wire logic stall_i,
    input  wire logic sync_req_i,
    // Receiver pins
    output logic      ready_o,
    output logic      sync_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase; // Stall phase counter
    initial begin
        phase = 2'h0;
        ready_o = 1'b1;
        sync_n_o = 1'b1;
    end
    // Slow mode drops ready one cycle in four so the FIFO sees back-pressure
    always @(posedge clk_i) begin
        phase <= phase + 2'h1;
        ready_o <= !(stall_i && phase == 2'h3);
        sync_n_o <= !sync_req_i;
    end
endmodule // rx_partner

// *** verification/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst_n = 0, link_en = 0, stall = 0, sync_req = 0;
    logic [3:0] tsel = 4'h0;    // Pattern select
    logic [4:0] cfg = 5'h0a;    // Link configuration, dual link by default
    logic valid, ready, sync_n, a_k, b_k, b_en, data_ph;
    logic [7:0] lane_a, lane_b; // Lane octets
    logic [8:0] q[$];           // Octets accepted by the receiver
    logic [8:0] o;
    int failures = 0, checks = 0;
    always #25 mclk = ~mclk;
    jesd_tx_test_pattern_gen #(.ILAS_MF(1)) jesd_tx_test_pattern_gen_inst (
        .MCLK_I(mclk), .RESETN_I(rst_n), .CE_I(1'b1), .LINK_EN_I(link_en),
        .TEST_PATTERN_SELECT_I(tsel), .LINK_CONFIG_MODE_I(cfg), .SYNC_N_I(sync_n),
        .LANE_READY_I(ready), .LANE_VALID_O(valid), .LANE_A0_O(lane_a), .LANE_A0_K_O(a_k),
        .LANE_B0_O(lane_b), .LANE_B0_K_O(b_k), .LANE_B_EN_O(b_en), .LINK_DATA_O(data_ph));
    rx_partner rx_partner_inst (.clk_i(mclk), .stall_i(stall), .sync_req_i(sync_req),
        .ready_o(ready), .sync_n_o(sync_n));
    task check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Capture every accepted octet; both links must match
    always @(posedge mclk) begin
        if (valid && ready) begin
            q.push_back({a_k, lane_a});
            check({b_k, lane_b}, {a_k, lane_a});
        end
    end
    // Mode changes only with the link down
    task start(input logic [3:0] sel);
        @(negedge mclk) link_en = 0;
        tsel = sel;
        repeat (3) @(negedge mclk);
        q.delete();
        link_en = 1;
    endtask
    task pop(output logic [8:0] v);
        int n;
        n = 0;
        while (q.size() == 0 && n < 500) begin
            @(posedge mclk);
            n++;
        end
        if (q.size() == 0) begin
            failures++;
            end_sim();
        end else v = q.pop_front();
    endtask
    // Skip until a given octet; a miss within the limit is a mismatch
    task seek(input logic [8:0] t);
        int n;
        n = 0;
        do begin
            pop(o);
            n++;
        end while (o !== t && n < 80);
        check(o, t);
    endtask
    function automatic logic [8:0] long_oct(int i);
        int f, w;
        logic [15:0] word;
        f = (i / 4) % 10;
        w = (i % 4) / 2;
        word = (f == 0) ? 16'((w + 1) * 2 + (w == 0 ? 1 : 0)) :
               (f == 1) ? 16'(2 + w) : 16'h8000;
        return (i % 2 == 0) ? {1'b0, word[15:8]} : {1'b0, word[7:0]};
    endfunction
    task t_raw;
        logic [7:0] rp [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
                                8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
        start(4'h2);
        for (int i = 0; i < 20; i++) begin pop(o); check(o, 9'h0b5); end
        start(4'h3);
        for (int i = 0; i < 20; i++) begin pop(o); check(o, 9'h1bc); end
        @(negedge mclk) stall = 1;
        start(4'h5);
        for (int i = 0; i < 36; i++) begin pop(o); check(o, {1'b0, rp[i % 12]}); end
        @(negedge mclk) stall = 0;
    endtask
    task t_long;
        start(4'h1);
        seek(9'h11c);
        repeat (39) pop(o);
        for (int i = 0; i < 80; i++) begin
            pop(o);
            check(o, long_oct(i));
        end
        check({8'h0, data_ph}, 9'h001);
        check({8'h0, b_en}, 9'h001);
    endtask
    // Plain link in the single-link configuration: zero payload, B lanes off
    task t_none_single;
        @(negedge mclk) cfg = 5'h0f;
        start(4'h0);
        seek(9'h11c);
        repeat (39) pop(o);
        for (int i = 0; i < 8; i++) begin
            pop(o);
            check(o, 9'h000);
        end
        check({8'h0, data_ph}, 9'h001);
        check({8'h0, b_en}, 9'h000);
    endtask
    task t_rep_ilas;
        start(4'h4);
        seek(9'h11c);
        repeat (39) pop(o);
        pop(o);
        check(o, 9'h11c);
        check({8'h0, data_ph}, 9'h000);
        @(negedge mclk) sync_req = 1;
        repeat (20) @(negedge mclk);
        q.delete();
        seek(9'h1bc);
        @(negedge mclk) sync_req = 0;
        seek(9'h11c);
    endtask
    initial begin
        #2000000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (16) @(negedge mclk);
        rst_n = 1;
        t_raw();
        t_long();
        t_none_single();
        t_rep_ilas();
        end_sim();
    end
endmodule // testbench
